// ==== dv/enc_model.sv ====
// enc_model: stand-in for an incremental or serial absolute encoder
// assumes step requests arrive at least four clk cycles apart
`timescale 1ns/1ps
`default_nettype none
module enc_model #(parameter int REV = 16) (
   input wire logic clk,         // bench clock
   input wire logic stepReq,     // advance one edge
   input wire logic stepUp,      // advance direction
   input wire logic stepMode,    // step/direction wiring
   input wire logic ssiMode,     // z pin carries serial data
   input wire logic serClk,      // serial clock in
   input wire logic [4:0] bits,  // word width n
   input wire logic gray,        // send gray code
   input wire logic [24:0] word, // absolute position
   output logic chA,             // a or step
   output logic chB,             // b or direction
   output logic zPin             // index or serial data
);
   logic [31:0] phase = 32'h0;
   logic [24:0] tx;
   logic lastClk = 1'h1;
   logic dat = 1'h1;
   int stable = 999;
   int k = 0;
   // one channel moves per step, so a leads b going up
   always @(posedge clk) begin
      if (stepReq) begin
         phase <= stepUp ? phase + 32'h1 : phase - 32'h1;
      end
   end
   assign chA = stepMode ? phase[0] : phase[1] ^ phase[0];
   assign chB = stepMode ? stepUp : phase[1];
   assign tx = gray ? word ^ (word >> 1) : word;
   // fresh bit after each falling clock; line drops low after the word and
   // only returns high once the clock has stood still, so stale bits never linger
   always @(posedge clk) begin
      lastClk <= serClk;
      stable <= (serClk != lastClk) ? 0 : stable + 1;
      if (lastClk && !serClk) begin
         k = (stable > 100) ? 1 : k + 1;
         dat <= (k >= 2 && k <= bits + 1) ? tx[bits + 1 - k] : 1'h0;
      end else if (stable > 100) begin
         dat <= 1'h1;
      end
   end
   // index once per revolution of REV edges
   assign zPin = ssiMode ? dat : (phase % REV) == 0;
endmodule // enc_model
`default_nettype wire

// ==== dv/encoder_interface_test.sv ====
// encoder_interface_test: self-checking bench for the encoder front end
// assumes the design carries its own assertions; reads are checked from a queue
`timescale 1ns/1ps
`default_nettype none
module encoder_interface_test;
   import encoder_pkg::*;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wrData = 32'h0;
   logic wrStrobe = 1'h0;
   logic rdStrobe = 1'h0;
   logic rdValid = 1'h0;
   logic [31:0] demandPos = 32'h0;
   logic [1:0] digIn = 2'h0;
   logic stepReq = 1'h0;
   logic stepUp = 1'h1;
   logic stepMode = 1'h0;
   logic ssiMode = 1'h0;
   logic [4:0] bits = 5'h0;
   logic gray = 1'h0;
   logic [24:0] word = 25'h0;
   logic chanA, chanB, indexZ, outA, outB, pso, captureDone, aEn, bEn;
   logic [31:0] rdData, followError, pos, base;
   logic [31:0] rnd = 32'h27;
   logic [31:0] expQ[$];
   logic [31:0] capCtl[3] = '{32'h1A04, 32'h1404, 32'h1E04};
   logic capLvl[3] = '{1'h1, 1'h0, 1'h1};
   int capBit[3] = '{0, 1, 1};
   int fails = 0;
   int samples_checked = 0;
   int len, e0, n;
   int edges = 0;
   logic [1:0] lastAB = 2'h0;
   encoder_interface encoder_interface_i (.clk(clk), .reset(reset), .addr(addr),
      .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
      .demandPos(demandPos), .chanA(chanA), .chanB(chanB), .indexZ(indexZ), .digIn(digIn),
      .outA(outA), .outAEn(aEn), .outB(outB), .outBEn(bEn), .position_switch_output(pso),
      .followError(followError), .captureDone(captureDone));
   enc_model enc_model_i (.clk(clk), .stepReq(stepReq), .stepUp(stepUp),
      .stepMode(stepMode), .ssiMode(ssiMode), .serClk(outA), .bits(bits), .gray(gray),
      .word(word), .chA(chanA), .chB(chanB), .zPin(indexZ));
   // 20 MHz clock
   always #25 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'h1;
      @(posedge clk);
      wrStrobe <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'h1;
      expQ.push_back(e);
      @(posedge clk);
      rdStrobe <= 1'h0;
   endtask
   // read data stands only in the cycle after the strobe; pair it with the oldest note
   always @(posedge clk) begin
      rdValid <= rdStrobe;
      if (rdValid) begin
         check(rdData, expQ.pop_front());
      end
   end
   // count every edge on the two emulation outputs
   always @(negedge clk) begin
      edges <= edges + int'(outA != lastAB[1]) + int'(outB != lastAB[0]);
      lastAB <= {outA, outB};
   end
   task automatic step(input int s);
      repeat (s < 0 ? -s : s) begin
         @(posedge clk);
         stepUp <= (s > 0);
         stepReq <= 1'h1;
         @(posedge clk);
         stepReq <= 1'h0;
         repeat (4) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask
   // length of the current level of the serial clock, in cycles
   task automatic run(input logic lvl);
      len = 0;
      while (outA === lvl && len < 1000) begin
         @(negedge clk);
         len++;
      end
   endtask
   // opposite level first (a wrong edge only if the pin stood at lvl) must leave the capture alone, then the chosen edge takes it
   task automatic capt(input logic [31:0] c, input int b, input logic lvl);
      wr(ADDR_CONTROL, c);
      digIn <= b ? {~lvl, digIn[0]} : {digIn[1], ~lvl};
      repeat (12) @(posedge clk);
      check({31'h0, captureDone}, 32'h0);
      digIn <= b ? {lvl, digIn[0]} : {digIn[1], lvl};
      len = 0;
      while (captureDone !== 1'h1 && len < 40) begin
         @(negedge clk);
         len++;
      end
      check({31'h0, len <= CAPTURE_CYCLES}, 32'h1);
   endtask
   initial begin
      #(50 * 60000);
      fails++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'h0;
      rd(ADDR_CONTROL, CONTROL_RESET);
      rd(4'hF, 32'h0);
      step(8);
      rd(ADDR_POSITION, 32'h8);
      step(-3);
      rd(ADDR_POSITION, 32'h5);
      check({30'h0, aEn, bEn}, 32'h0);
      wr(ADDR_CONTROL, 32'h0);
      stepMode <= 1'h1;
      step(4);
      rd(ADDR_POSITION, 32'h7);
      step(-4);
      rd(ADDR_POSITION, 32'h5);
      wr(ADDR_CONTROL, CONTROL_RESET);
      stepMode <= 1'h0;
      $display("test counting done");
      pos = 32'h5;
      for (int i = 0; i < 3; i++) begin
         capt(capCtl[i], capBit[i], capLvl[i]);
         step(1);
         rd(ADDR_CAPTURE, pos);
         pos++;
      end
      rd(ADDR_STATUS, 32'h2);
      $display("test capture done");
      rnd = xs(rnd);
      base = rnd;
      wr(ADDR_POSITION, base);
      wr(ADDR_SWITCH_ON, base + 32'h2);
      wr(ADDR_SWITCH_OFF, base + 32'h5);
      wr(ADDR_CONTROL, 32'h2004);
      for (int i = 1; i < 7; i++) begin
         step(1);
         check({31'h0, pso}, {31'h0, i >= 2 && i < 5});
      end
      $display("test switch done");
      wr(ADDR_CONTROL, 32'h5);
      e0 = edges;
      wr(ADDR_EMUL_STEP, 32'h6);
      repeat (30) @(posedge clk);
      wr(ADDR_EMUL_STEP, 32'hFFFF_FFFD);
      repeat (30) @(posedge clk);
      check(edges - e0, 32'h9);
      rd(ADDR_POSITION, base + 32'h9);
      check({30'h0, aEn, bEn}, 32'h3);
      $display("test emulation done");
      // second reset in mid-run before the serial runs
      @(posedge clk);
      reset <= 1'h1;
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      rd(ADDR_POSITION, 32'h0);
      for (int j = 0; j < 2; j++) begin
         n = j ? 12 : 25;
         rnd = xs(rnd);
         pos = j ? {20'h0, rnd[11:0]} : {7'h0, rnd[24:0]};
         bits <= n[4:0];
         gray <= j[0];
         word <= pos[24:0];
         ssiMode <= 1'h1;
         wr(ADDR_CONTROL, j ? 32'h00CE : 32'h0196);
         len = 0;
         for (int t = 0; t < 40 && len < 200; t++) begin
            run(1'h0);
            run(1'h1);
         end
         for (int p = 0; p < n + 2; p++) begin
            run(1'h0);
            check(len, SER_HALF_CYCLES);
            run(1'h1);
            check(len, p == n + 1 ? SER_HALF_CYCLES + SER_GAP_CYCLES : SER_HALF_CYCLES);
         end
         rd(ADDR_POSITION, pos);
         demandPos <= xs(rnd);
         repeat (4) @(posedge clk);
         check(followError, demandPos - pos);
         check({30'h0, aEn, bEn}, 32'h2);
      end
      // a width above the limit is clamped to the largest word
      wr(ADDR_CONTROL, 32'h01F0);
      rd(ADDR_CONTROL, 32'h0190);
      $display("test serial done");
      repeat (4) @(posedge clk);
      close_out();
   end
endmodule // encoder_interface_test
`default_nettype wire

// ==== rtl/encoder_interface.sv ====
// encoder_interface: incremental/ssi position front end with capture and switch
// assumes pins are asynchronous to clk and the register port is on clk
`timescale 1ns/1ps
`default_nettype none
module encoder_interface
   import encoder_pkg::*;
(
   input wire logic clk,               // 20 MHz core clock
   input wire logic reset,             // async, active high
   input wire logic [3:0] addr,        // register address
   input wire logic [31:0] wrData,     // write data
   input wire logic wrStrobe,          // write strobe
   input wire logic rdStrobe,          // read strobe
   output logic [31:0] rdData,         // read data, cycle after strobe
   input wire logic [31:0] demandPos,  // servo demand for following error
   input wire logic chanA,             // a / step pin
   input wire logic chanB,             // b / direction pin
   input wire logic indexZ,            // z index / serial data pin
   input wire logic [1:0] digIn,       // digital inputs 0 and 1
   output logic outA,                  // a / serial clock output
   output logic outAEn,                // drive enable for a pin
   output logic outB,                  // b output
   output logic outBEn,                // drive enable for b pin
   output logic position_switch_output, // digital output 8
   output logic [31:0] followError,    // demand minus measured
   output logic captureDone            // capture taken, level
);
   logic [1:0] syncA, syncB, syncZ, syncD0, syncD1;
   logic prevA_reg, prevB_reg, prevZ_reg, prevD0_reg, prevD1_reg;
   logic [31:0] control_reg, control_next;
   logic [31:0] measured_position, position_next;
   logic [31:0] capture_reg, capture_next;
   logic [31:0] swOn_reg, swOn_next, swOff_reg, swOff_next;
   logic [31:0] rd_reg, rd_next;
   logic [31:0] ferr_reg, ferr_next;
   logic armed_reg, armed_next, capDone_reg, capDone_next;
   logic sw_reg, sw_next;
   logic [31:0] emulCmd_reg, emulCmd_next;
   logic [1:0] emulPh_reg, emulPh_next;
   logic ea_reg, eb_reg, aEn_reg, bEn_reg;
   logic [2:0] warm_reg; // edges ignored until prev flops hold real pin levels
   logic serClk;
   logic [31:0] serBin;
   mode_t mode;
   logic quadMode, grayMode, edgeRise, capture_arm_command, hw_position_switch_command;
   logic [4:0] bitCount;
   logic [1:0] capSrc;
   logic curA, curB, edgeA, edgeB, inc, dec, trigLvl, trigPrev, trig;
   logic [31:0] serWord;
   ser_link_if link ();

   initial begin
      if (CAPTURE_CYCLES < 2) $error("capture window too short for synchroniser");
   end

   // two-flop synchronisers; only the second stage is read
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         syncA <= 2'b00;
         syncB <= 2'b00;
         syncZ <= 2'b00;
         syncD0 <= 2'b00;
         syncD1 <= 2'b00;
         warm_reg <= 3'b000;
      end else begin
         syncA <= {syncA[0], chanA};
         syncB <= {syncB[0], chanB};
         syncZ <= {syncZ[0], indexZ};
         syncD0 <= {syncD0[0], digIn[0]};
         syncD1 <= {syncD1[0], digIn[1]};
         warm_reg <= {warm_reg[1:0], 1'b1};
      end
   end

   // control field decode
   always_comb begin
      mode = mode_t'(control_reg[CTL_MODE_LO +: 2]);
      quadMode = control_reg[CTL_QUAD];
      grayMode = control_reg[CTL_GRAY];
      bitCount = control_reg[CTL_BITS_LO +: 5];
      capSrc = control_reg[CTL_SRC_LO +: 2];
      edgeRise = control_reg[CTL_EDGE];
      capture_arm_command = control_reg[CTL_ARM];
      hw_position_switch_command = control_reg[CTL_SWEN];
   end

   // quadrature / step-dir edge decoding
   always_comb begin
      curA = syncA[1];
      curB = syncB[1];
      edgeA = (curA ^ prevA_reg) && warm_reg[2];
      edgeB = (curB ^ prevB_reg) && warm_reg[2];
      inc = 1'b0;
      dec = 1'b0;
      if (quadMode) begin
         // a edge with a!=b or b edge with a==b means a leads
         if (edgeA && !edgeB) begin
            inc = (curA != curB);
            dec = (curA == curB);
         end else if (edgeB && !edgeA) begin
            inc = (curA == curB);
            dec = (curA != curB);
         end
      end else if (curA && !prevA_reg && warm_reg[2]) begin
         inc = curB;
         dec = !curB;
      end
   end

   // gray to binary for serial words, msb aligned to the word width
   always_comb begin
      serWord = 32'h0000_0000;
      for (int i = 0; i < SER_MAX_BITS; i++)
         if (i < int'(bitCount)) serWord[i] = link.word[i];
      serBin = serWord;
      if (grayMode)
         for (int i = SER_MAX_BITS - 2; i >= 0; i--)
            serBin[i] = serBin[i + 1] ^ serWord[i];
   end

   // capture trigger source select
   always_comb begin
      unique case (capSrc)
         2'b00: begin
            trigLvl = syncZ[1];
            trigPrev = prevZ_reg;
         end
         2'b01: begin
            trigLvl = syncD0[1];
            trigPrev = prevD0_reg;
         end
         default: begin
            trigLvl = syncD1[1];
            trigPrev = prevD1_reg;
         end
      endcase
      trig = warm_reg[2] && (edgeRise ? (trigLvl && !trigPrev) : (!trigLvl && trigPrev));
   end

   // position, capture, switch, emulation and register writes
   always_comb begin
      control_next = control_reg;
      position_next = measured_position;
      capture_next = capture_reg;
      swOn_next = swOn_reg;
      swOff_next = swOff_reg;
      armed_next = armed_reg;
      capDone_next = capDone_reg;
      sw_next = sw_reg;
      emulCmd_next = emulCmd_reg;
      emulPh_next = emulPh_reg;
      ferr_next = demandPos - measured_position;
      if (mode == MODE_INCR) begin
         if (inc) position_next = measured_position + 32'h0000_0001;
         else if (dec) position_next = measured_position - 32'h0000_0001;
      end else if (mode == MODE_SSI && link.done) begin
         position_next = serBin;
      end
      // emulation: step phase one quarter per count, single pin edge each
      if (mode == MODE_EMUL && emulCmd_reg != 32'h0000_0000) begin
         if (emulCmd_reg[31]) begin
            emulPh_next = emulPh_reg - 2'b01;
            emulCmd_next = emulCmd_reg + 32'h0000_0001;
            position_next = measured_position - 32'h0000_0001;
         end else begin
            emulPh_next = emulPh_reg + 2'b01;
            emulCmd_next = emulCmd_reg - 32'h0000_0001;
            position_next = measured_position + 32'h0000_0001;
         end
      end
      // capture latches the count that the edge saw, no software path
      if (armed_reg && trig && mode != MODE_EMUL) begin
         capture_next = measured_position;
         armed_next = 1'b0;
         capDone_next = 1'b1;
      end
      if (hw_position_switch_command) begin
         if (measured_position == swOn_reg) sw_next = 1'b1;
         else if (measured_position == swOff_reg) sw_next = 1'b0;
      end else begin
         sw_next = 1'b0;
      end
      if (wrStrobe) begin
         unique case (addr)
            ADDR_CONTROL: begin
               control_next = wrData;
               control_next[CTL_ARM] = 1'b0;
               if (wrData[CTL_BITS_LO +: 5] > 5'(SER_MAX_BITS))
                  control_next[CTL_BITS_LO +: 5] = 5'(SER_MAX_BITS);
               // arming clears done; a capture in the same cycle still wins
               if (wrData[CTL_ARM]) begin
                  armed_next = !(armed_reg && trig);
                  capDone_next = armed_reg && trig;
               end
            end
            ADDR_POSITION: position_next = wrData;
            ADDR_SWITCH_ON: swOn_next = wrData;
            ADDR_SWITCH_OFF: swOff_next = wrData;
            ADDR_EMUL_STEP: emulCmd_next = wrData;
            default: ;
         endcase
      end
   end

   // read mux, data valid the cycle after the strobe only
   always_comb begin
      rd_next = 32'h0000_0000;
      if (rdStrobe) begin
         unique case (addr)
            ADDR_CONTROL: rd_next = control_reg;
            ADDR_POSITION: rd_next = measured_position;
            ADDR_CAPTURE: rd_next = capture_reg;
            ADDR_SWITCH_ON: rd_next = swOn_reg;
            ADDR_SWITCH_OFF: rd_next = swOff_reg;
            ADDR_STATUS: rd_next = {29'h0, sw_reg, capDone_reg, armed_reg};
            ADDR_EMUL_STEP: rd_next = emulCmd_reg;
            default: rd_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         control_reg <= CONTROL_RESET;
         measured_position <= 32'h0000_0000;
         capture_reg <= 32'h0000_0000;
         swOn_reg <= 32'h0000_0000;
         swOff_reg <= 32'h0000_0000;
         rd_reg <= 32'h0000_0000;
         ferr_reg <= 32'h0000_0000;
         armed_reg <= 1'b0;
         capDone_reg <= 1'b0;
         sw_reg <= 1'b0;
         emulCmd_reg <= 32'h0000_0000;
         emulPh_reg <= 2'b00;
         prevA_reg <= 1'b0;
         prevB_reg <= 1'b0;
         prevZ_reg <= 1'b0;
         prevD0_reg <= 1'b0;
         prevD1_reg <= 1'b0;
         ea_reg <= 1'b0;
         eb_reg <= 1'b0;
         aEn_reg <= 1'b0;
         bEn_reg <= 1'b0;
      end else begin
         control_reg <= control_next;
         measured_position <= position_next;
         capture_reg <= capture_next;
         swOn_reg <= swOn_next;
         swOff_reg <= swOff_next;
         rd_reg <= rd_next;
         ferr_reg <= ferr_next;
         armed_reg <= armed_next;
         capDone_reg <= capDone_next;
         sw_reg <= sw_next;
         emulCmd_reg <= emulCmd_next;
         emulPh_reg <= emulPh_next;
         prevA_reg <= syncA[1];
         prevB_reg <= syncB[1];
         prevZ_reg <= syncZ[1];
         prevD0_reg <= syncD0[1];
         prevD1_reg <= syncD1[1];
         // gray phase sequence 00,10,11,01 on a/b, serial clock on a in ssi mode
         ea_reg <= (mode == MODE_SSI) ? serClk : (emulPh_next[1] ^ emulPh_next[0]);
         eb_reg <= emulPh_next[1];
         aEn_reg <= (mode != MODE_INCR); // a pin is an input while counting
         bEn_reg <= (mode == MODE_EMUL);
      end
   end

   // serial engine shares the z pin as data
   ssi_reader u_ssi (
      .clk(clk),
      .reset(reset),
      .enable(mode == MODE_SSI && bitCount != 5'h00),
      .bitCount(bitCount),
      .serData(syncZ[1]),
      .serClk(serClk),
      .link(link)
   );

   assign rdData = rd_reg;
   assign followError = ferr_reg;
   assign captureDone = capDone_reg;
   assign position_switch_output = sw_reg;
   assign outA = ea_reg;
   assign outB = eb_reg;
   assign outAEn = aEn_reg;
   assign outBEn = bEn_reg;

   chk_count_up: assert property (@(posedge clk) disable iff (reset)
      (mode == MODE_INCR && inc && !wrStrobe) |=> measured_position == $past(measured_position) + 32'h0000_0001)
      else $error("forward edge did not count up");
   chk_count_down: assert property (@(posedge clk) disable iff (reset)
      (mode == MODE_INCR && dec && !wrStrobe) |=> measured_position == $past(measured_position) - 32'h0000_0001)
      else $error("reverse edge did not count down");
   chk_single_count: assert property (@(posedge clk) disable iff (reset)
      !(inc && dec)) else $error("up and down at once");
   chk_capture_value: assert property (@(posedge clk) disable iff (reset)
      (armed_reg && trig && mode != MODE_EMUL) |=> capture_reg == $past(measured_position) && capDone_reg)
      else $error("capture missed position");
   chk_capture_fast: assert property (@(posedge clk) disable iff (reset)
      (armed_reg && trig && mode != MODE_EMUL) |-> ##1 !armed_reg)
      else $error("capture too slow");
   chk_switch_on: assert property (@(posedge clk) disable iff (reset)
      (hw_position_switch_command && measured_position == swOn_reg) |=> position_switch_output)
      else $error("switch did not turn on");
   chk_switch_off: assert property (@(posedge clk) disable iff (reset)
      (hw_position_switch_command && measured_position == swOff_reg && measured_position != swOn_reg)
      |=> !position_switch_output) else $error("switch did not turn off");
   chk_ssi_load: assert property (@(posedge clk) disable iff (reset)
      (mode == MODE_SSI && link.done && !wrStrobe) |=> measured_position == $past(serBin))
      else $error("serial word not loaded");
   chk_bits_limit: assert property (@(posedge clk) disable iff (reset)
      bitCount <= 5'(SER_MAX_BITS)) else $error("bit count above limit");
endmodule : encoder_interface
`default_nettype wire

// ==== rtl/encoder_pkg.sv ====
// encoder_pkg: shared constants and types for the encoder front end
// assumes a 20 MHz core clock and a register port with one-cycle read latency
`default_nettype none
package encoder_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int SER_CLK_HZ = 200000;
   localparam int SER_HALF_CYCLES = CLK_HZ / (2 * SER_CLK_HZ);
   localparam int SER_GAP_US = 32;
   localparam int SER_GAP_CYCLES = (SER_GAP_US * (CLK_HZ / 1000000));
   localparam int CAPTURE_NS = 500;
   localparam int CAPTURE_CYCLES = (CAPTURE_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int POS_W = 32;
   localparam int SER_MAX_BITS = 25;
   localparam int SER_EXTRA_PULSES = 2;
   // register addresses
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_POSITION = 4'h1;
   localparam logic [3:0] ADDR_CAPTURE = 4'h2;
   localparam logic [3:0] ADDR_SWITCH_ON = 4'h3;
   localparam logic [3:0] ADDR_SWITCH_OFF = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   localparam logic [3:0] ADDR_EMUL_STEP = 4'h6;
   // control field positions
   localparam int CTL_MODE_LO = 0;
   localparam int CTL_QUAD = 2;
   localparam int CTL_GRAY = 3;
   localparam int CTL_BITS_LO = 4;
   localparam int CTL_SRC_LO = 9;
   localparam int CTL_EDGE = 11;
   localparam int CTL_ARM = 12;
   localparam int CTL_SWEN = 13;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0004;
   typedef enum logic [1:0] {MODE_INCR, MODE_EMUL, MODE_SSI} mode_t;
   typedef enum {SER_IDLE, SER_LOW, SER_HIGH} ser_state_t;
endpackage : encoder_pkg
`default_nettype wire

// ==== rtl/ser_link_if.sv ====
// ser_link_if: frame results passed from the serial reader to the core
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface ser_link_if;
   logic [31:0] word;   // received word, msb-aligned to bit count
   logic done;          // one-cycle frame complete pulse
   modport reader (output word, output done);
   modport core (input word, input done);
endinterface : ser_link_if
`default_nettype wire

// ==== rtl/ssi_reader.sv ====
// ssi_reader: continuous serial absolute frame engine
// assumes serData already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module ssi_reader
   import encoder_pkg::*;
(
   input wire logic clk,             // core clock
   input wire logic reset,           // async, active high
   input wire logic enable,          // run frames
   input wire logic [4:0] bitCount,  // position word width n
   input wire logic serData,         // synchronised data
   output logic serClk,              // clock to encoder, idles high
   ser_link_if.reader link           // frame results
);
   localparam logic [15:0] HALF = 16'(SER_HALF_CYCLES);
   localparam logic [15:0] GAP = 16'(SER_GAP_CYCLES);
   ser_state_t state_reg, state_next;
   logic [15:0] timer_reg, timer_next;
   logic [5:0] pulse_reg, pulse_next;
   logic [31:0] shift_reg, shift_next;
   logic clk_reg, clk_next, done_reg, done_next;
   // frame sequencing: n+2 pulses, then 32 us idle, repeat
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg - 16'h0001;
      pulse_next = pulse_reg;
      shift_next = shift_reg;
      clk_next = clk_reg;
      done_next = 1'b0;
      unique case (state_reg)
         SER_IDLE: begin
            clk_next = 1'b1;
            if (!enable) timer_next = GAP;
            else if (timer_reg == 16'h0000) begin
               state_next = SER_LOW;
               clk_next = 1'b0;
               timer_next = HALF - 16'h0001;
               pulse_next = 6'h00;
            end
         end
         SER_LOW: if (timer_reg == 16'h0000) begin
            state_next = SER_HIGH;
            clk_next = 1'b1;
            timer_next = HALF - 16'h0001;
            // data valid around the rising edge, msb first; skip first pulse
            if (pulse_reg != 6'h00 && pulse_reg <= {1'b0, bitCount})
               shift_next = {shift_reg[30:0], serData};
         end
         SER_HIGH: if (timer_reg == 16'h0000) begin
            if (pulse_reg == {1'b0, bitCount} + 6'(SER_EXTRA_PULSES - 1)) begin
               state_next = SER_IDLE;
               timer_next = GAP - 16'h0001;
               done_next = 1'b1;
            end else begin
               state_next = SER_LOW;
               clk_next = 1'b0;
               timer_next = HALF - 16'h0001;
               pulse_next = pulse_reg + 6'h01;
            end
         end
      endcase
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= SER_IDLE;
         timer_reg <= 16'h0000;
         pulse_reg <= 6'h00;
         shift_reg <= 32'h0000_0000;
         clk_reg <= 1'b1;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         pulse_reg <= pulse_next;
         shift_reg <= shift_next;
         clk_reg <= clk_next;
         done_reg <= done_next;
      end
   end
   assign serClk = clk_reg;
   assign link.word = shift_reg;
   assign link.done = done_reg;
   chk_gap_length: assert property (@(posedge clk) disable iff (reset)
      $rose(done_reg) |-> serClk [*8]) else $error("serial clock not idle after frame");
endmodule : ssi_reader
`default_nettype wire
